//--- hdl/pwmext_pkg.sv
// Package for the waveform extension with fault recovery.
// Assumes one 10 MHz clock and a plain register port.
package pwmext_pkg;
  // Clock period, ns
  localparam int CLK_PERIOD_NS = 100;
  // Longest bad drive after fault exit: two periods plus a quarter period
  localparam int GLITCH_MAX_NS = 225;
  // Longest time, rounded down, at least one cycle
  localparam int GLITCH_RAW = GLITCH_MAX_NS / CLK_PERIOD_NS;
  localparam int GLITCH_CYCLES = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DTOE = 8'h01;
  localparam logic [7:0] REG_PATTERN = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h03;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h05;
  // Control field positions
  localparam int CTRL_PGM_BIT = 0;
  localparam int CTRL_COMMON_WAVEFORM_CHANNEL_MODE_BIT = 1;
  // Status field positions
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  localparam int ST_RECOV_BIT = 2;
  localparam int ST_WIDTH = 3;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DTOE_RESET = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // Output path states
  typedef enum logic [1:0] {
    PWMEXT_RUN = 2'b00,
    PWMEXT_FAULT = 2'b01,
    PWMEXT_WAIT = 2'b10
  } pwmext_state_e;
endpackage

//--- hdl/pwmext_dead_time.sv
// One dead-time pair: high and low side from one compare level.
// Assumes the compare level comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pwmext_dead_time #(
  parameter int DT_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Compare level and output enable
  input wire logic cmp_i,
  input wire logic en_i,
  // Pair outputs
  output logic hi_o,
  output logic lo_o
);
  logic last; // Previous compare level
  logic [7:0] cnt; // Remaining dead cycles
  logic next_last;
  logic [7:0] next_cnt;

  // Reload the dead gap on each compare edge
  always_comb begin
    next_last = cmp_i;
    next_cnt = cnt;
    if (cmp_i != last) begin
      next_cnt = 8'(DT_CYCLES);
    end else if (cnt != 8'h00) begin
      next_cnt = cnt - 8'h01;
    end
  end

  // Register the gap state
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      last <= 1'b0;
      cnt <= 8'h00;
    end else begin
      last <= next_last;
      cnt <= next_cnt;
    end
  end

  // Both sides off during the gap or while disabled
  assign hi_o = en_i & cmp_i & (cnt == 8'h00) & (cmp_i == last);
  assign lo_o = en_i & ~cmp_i & (cnt == 8'h00) & (cmp_i == last);
endmodule
`default_nettype wire

//--- hdl/pwmext_top.sv
// Waveform extension: mode decode, dead time, pattern, fault recovery.
// Assumes compare and overflow from a timer on the same clock,
// and an asynchronous fault pin.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Decode pattern and common-waveform bits per table
// - Bad drive after fault limited to bound
// - First period after re-enable may be short
// - Pattern mode glitch unavoidable, still bounded
module pwmext_top
  import pwmext_pkg::*;
#(
  parameter int CH = 4,
  parameter int DT_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Timer side
  input wire logic [CH-1:0] cmp_i,
  input wire logic overflow_i,
  // Fault pin
  input wire logic fault_pin_i,
  // Pin side waveforms, pairs high then low
  output logic [2*CH-1:0] wave_o,
  // Interrupt
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl; // Mode bits
  logic [7:0] dtoe; // Dead-time output enables
  logic [7:0] pattern; // Pattern pin mask
  logic [ST_WIDTH-1:0] status; // Sticky events
  logic [ST_WIDTH-1:0] mask; // Interrupt mask
  logic [7:0] next_ctrl, next_dtoe, next_pattern, next_rdata;
  logic [ST_WIDTH-1:0] next_status, next_mask;
  logic next_irq;
  logic [ST_WIDTH-1:0] ev; // Event set pulses
  pwmext_state_e state, next_state;
  // Fault pin synchroniser
  logic sync1, sync2, sync3, fault_lvl, next_fault_lvl;
  logic fault_rise;
  // Mode decode and waveform path
  logic en_pg, en_cw;
  logic [CH-1:0] src;
  logic [2*CH-1:0] raw, gated, next_wave;

  ////////////////////////////////////////////////////////////////////
  // Fault pin: change taken once second and third stage agree
  always_comb begin
    next_fault_lvl = (sync2 == sync3) ? sync3 : fault_lvl;
  end

  // Synchroniser flops
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      fault_lvl <= 1'b0;
    end else begin
      sync1 <= fault_pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
      fault_lvl <= next_fault_lvl;
    end
  end
  assign fault_rise = next_fault_lvl & ~fault_lvl;

  ////////////////////////////////////////////////////////////////////
  // Mode decode: pattern on if either bit set, common only 1/0
  assign en_pg = ctrl[CTRL_PGM_BIT] | ctrl[CTRL_COMMON_WAVEFORM_CHANNEL_MODE_BIT];
  assign en_cw = ctrl[CTRL_PGM_BIT] & ~ctrl[CTRL_COMMON_WAVEFORM_CHANNEL_MODE_BIT];

  // Dead-time pairs, one per channel
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : gen_ch
      // Common mode feeds every channel from channel zero
      assign src[g] = en_cw ? cmp_i[0] : cmp_i[g];
      // Enable takes effect at once, so first period may be short
      pwmext_dead_time #(.DT_CYCLES(DT_CYCLES)) u_dt (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .cmp_i(src[g]),
        .en_i(dtoe[g]),
        .hi_o(raw[2*g]),
        .lo_o(raw[2*g+1])
      );
    end
  endgenerate

  // Pattern mode drives only masked pins
  assign gated = en_pg ? (raw & pattern[2*CH-1:0]) : raw;

  ////////////////////////////////////////////////////////////////////
  // Fault state machine and output register
  always_comb begin
    next_state = state;
    ev = '0;
    unique case (state)
      PWMEXT_RUN: begin
        if (fault_rise) begin
          next_state = PWMEXT_FAULT;
        end
      end
      PWMEXT_FAULT: begin
        // Hold until flag cleared and pin quiet
        if (!status[ST_FAULT_BIT] && !fault_lvl) begin
          next_state = PWMEXT_WAIT;
        end
      end
      PWMEXT_WAIT: begin
        if (fault_rise) begin
          next_state = PWMEXT_FAULT;
        end else if (overflow_i) begin
          next_state = PWMEXT_RUN;
          ev[ST_RECOV_BIT] = 1'b1;
        end
      end
      // Unused code falls back to normal running
      default: begin
        next_state = PWMEXT_RUN;
      end
    endcase
    ev[ST_FAULT_BIT] = fault_rise;
    ev[ST_OVF_BIT] = overflow_i;
    // Outputs off in fault; valid from the same edge that returns to run
    next_wave = (next_state == PWMEXT_RUN) ? gated : '0;
  end

  // Register state and pins
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= PWMEXT_RUN;
      wave_o <= '0;
    end else begin
      state <= next_state;
      wave_o <= next_wave;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port: writes, W1C status with set winning, reads
  always_comb begin
    next_ctrl = ctrl;
    next_dtoe = dtoe;
    next_pattern = pattern;
    next_mask = mask;
    next_status = status;
    next_rdata = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        REG_CTRL: next_ctrl = wdata_i;
        REG_DTOE: next_dtoe = wdata_i;
        REG_PATTERN: next_pattern = wdata_i;
        REG_MASK: next_mask = wdata_i[ST_WIDTH-1:0];
        REG_STATUS: next_status = status & ~wdata_i[ST_WIDTH-1:0];
        default: ; // Unmapped writes ignored
      endcase
    end
    next_status = next_status | ev;
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: next_rdata = ctrl;
        REG_DTOE: next_rdata = dtoe;
        REG_PATTERN: next_rdata = pattern;
        REG_STATUS: next_rdata = {5'h00, status};
        REG_MASK: next_rdata = {5'h00, mask};
        REG_STATE: next_rdata = {5'h00, fault_lvl, state};
        default: next_rdata = 8'h00; // Unmapped reads zero
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  // Register file flops
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      dtoe <= DTOE_RESET;
      pattern <= PATTERN_RESET;
      mask <= MASK_RESET;
      status <= '0;
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      dtoe <= next_dtoe;
      pattern <= next_pattern;
      mask <= next_mask;
      status <= next_status;
      rdata_o <= next_rdata;
      irq_o <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_flag_clear;
    state == PWMEXT_FAULT && !status[ST_FAULT_BIT] && !fault_lvl;
  endsequence
  sequence s_ovf_resume;
    state == PWMEXT_WAIT && overflow_i && !fault_rise;
  endsequence

  mode_decode_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ctrl[CTRL_COMMON_WAVEFORM_CHANNEL_MODE_BIT] |-> !en_cw && en_pg) and
    (ctrl[1:0] == 2'b00 |-> !en_pg && !en_cw))
    else $error("mode decode wrong");
  glitch_bound_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == PWMEXT_RUN && $past(state) == PWMEXT_WAIT)
      |-> ##[0:1] wave_o == $past(gated))
    else $error("waveform not valid within bound");
  short_period_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == PWMEXT_RUN && next_state == PWMEXT_RUN && dtoe[0]
     && raw[0] && !en_pg) |=> wave_o[0])
    else $error("enabled output not driven");
  pattern_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (en_pg && fault_rise) |=> (wave_o == '0)[*2])
    else $error("pattern output not held off in fault");
  fault_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == PWMEXT_FAULT && status[ST_FAULT_BIT]) |=> state != PWMEXT_RUN)
    else $error("left fault with flag set");
  fault_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
    fault_rise |=> status[ST_FAULT_BIT] && state == PWMEXT_FAULT)
    else $error("fault flag not set");
  flag_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_flag_clear |=> state == PWMEXT_WAIT)
    else $error("flag clear did not arm recovery");
  wait_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == PWMEXT_WAIT && !overflow_i) |=> state != PWMEXT_RUN)
    else $error("left wait without overflow");
  recover_seq_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_ovf_resume |=> state == PWMEXT_RUN && status[ST_RECOV_BIT])
    else $error("recovery not at overflow");
  irq_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
    |(status & mask) |-> irq_o)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

//--- testbench/pwmext_stage_model.sv
// Power stage model on the pin side of the waveform extension.
// Assumes the block's clock; trip requests come from the bench.
`timescale 1ns/1ps
`default_nettype none
module pwmext_stage_model #(
  parameter int CH = 4
) (
  // Clock
  input wire logic clock_i,
  // Pin side waveforms and trip request
  input wire logic [2*CH-1:0] wave_i,
  input wire logic trip_i,
  // Overcurrent report
  output logic fault_o,
  // Sticky flag: some pair had both sides on
  output logic overlap_o
);
  logic fault = 1'b0; // Comparator state
  logic overlap = 1'b0; // Shoot-through seen
  // Report lags the trip by one edge, like a comparator
  always @(posedge clock_i) begin
    fault <= trip_i;
    // Both sides of one pair on would short the supply
    for (int c = 0; c < CH; c++) begin
      if (wave_i[2*c] && wave_i[2*c+1]) begin
        overlap <= 1'b1;
      end
    end
  end
  assign fault_o = fault;
  assign overlap_o = overlap;
endmodule
`default_nettype wire

//--- testbench/test_pwmext_top.sv
// Bench for the waveform extension: modes, fault hold and recovery.
// Assumes one 10 MHz clock and the stage model on the pins.
`timescale 1ns/1ps
`default_nettype none
module test_pwmext_top;
  import pwmext_pkg::*;
  // Clock, reset and register port
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  // Timer side, pins, interrupt
  logic [3:0] cmp_i = 4'h0;
  logic overflow_i = 1'b0;
  logic trip = 1'b0;
  logic fault_pin, irq_o, overlap;
  logic pend = 1'b0;
  logic [7:0] wave_o, pat;
  logic [7:0] exp_q[$];
  logic [7:0] ra[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h10};
  int n_fail = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////
  always #50 clock_i = ~clock_i;
  pwmext_top u_pwmext_top (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cmp_i(cmp_i), .overflow_i(overflow_i),
    .fault_pin_i(fault_pin), .wave_o(wave_o), .irq_o(irq_o));
  pwmext_stage_model u_pwmext_stage_model (.clock_i(clock_i),
    .wave_i(wave_o), .trip_i(trip), .fault_o(fault_pin),
    .overlap_o(overlap));
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // One write cycle, then a quiet edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // One read cycle; expected data waits in the queue
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clock_i) pend <= rd_i;
  always @(negedge clock_i) begin
    if (pend) begin
      check("rdata", rdata_o, exp_q.pop_front());
    end
  end
  // Pin levels from mode, compare levels and enables
  function automatic logic [7:0] exp_wave(input logic [7:0] ctrl,
                                          input logic [3:0] en);
    logic [7:0] w;
    logic l;
    w = 8'h00;
    for (int c = 0; c < 4; c++) begin
      l = (ctrl[0] & ~ctrl[1]) ? cmp_i[0] : cmp_i[c];
      w[2*c] = l & en[c];
      w[2*c+1] = ~l & en[c];
    end
    return (ctrl[0] | ctrl[1]) ? (w & pat) : w;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(97));
    pat = 8'($urandom);
    cyc(4);
    rst_i <= 1'b0;
    cyc(1);
    // Reset values, unmapped place reads zero
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(REG_DTOE, 8'h0F);
    wr(REG_PATTERN, pat);
    // Every mode code, random compare levels
    for (int m = 0; m < 4; m++) begin
      wr(REG_CTRL, 8'(m));
      repeat (2) begin
        cmp_i <= 4'($urandom);
        cyc(12);
        check("wave", wave_o, exp_wave(8'(m), 4'hF));
      end
    end
    rd(REG_CTRL, 8'h03);
    wr(REG_MASK, 8'h01);
    // Latched recovery with outputs disabled in fault, then pattern mode with them left on
    for (int k = 0; k < 2; k++) begin
      wr(REG_CTRL, k ? 8'h02 : 8'h00);
      trip <= 1'b1;
      cyc(8);
      check("held", wave_o, 8'h00);
      check("irq", {7'h00, irq_o}, 8'h01);
      rd(REG_STATE, 8'h05);
      if (k == 0) wr(REG_DTOE, 8'h00);
      trip <= 1'b0;
      cyc(6);
      wr(REG_STATUS, 8'h01);
      cyc(4);
      check("irq", {7'h00, irq_o}, 8'h00);
      check("wait", wave_o, 8'h00);
      rd(REG_STATE, 8'h02);
      overflow_i <= 1'b1;
      @(posedge clock_i);
      overflow_i <= 1'b0;
      if (k == 0) begin
        wr(REG_DTOE, 8'h0F);
        cyc(1);
        check("first", wave_o, exp_wave(8'h00, 4'hF));
      end else begin
        cyc(GLITCH_CYCLES);
        check("glitch", wave_o, exp_wave(8'h02, 4'hF));
      end
      rd(REG_STATUS, 8'h06);
      if (k == 0) wr(REG_STATUS, 8'h07);
    end
    // Unmask the other events, then clear them
    wr(REG_MASK, 8'h06);
    cyc(1);
    check("irq", {7'h00, irq_o}, 8'h01);
    wr(REG_STATUS, 8'h07);
    cyc(1);
    check("irq", {7'h00, irq_o}, 8'h00);
    check("overlap", {7'h00, overlap}, 8'h00);
    finish_test();
  end
  // Hang guard, far beyond the few hundred cycles used
  initial begin
    #500000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
